// File: verilog/pwm_timebase_defs.svh
// register map, field positions and reset values of the timebase block
// assumes a plain strobe bus with byte offsets as printed
//
// Contract
// [R01] reload every interval-plus-one opportunities
// [R02] new interval applies after current load cycle
// [R03] half-cycle reloads only in center mode
// [R04] divider codes give bus clock /1 /2 /4 /8
// [R05] divider applies at next cycle with load-okay
// [R06] reload flag sets on every reload
// [R07] flag clears by read then write one
// [R08] reload between read and write keeps flag
// [R09] clearing flag drops its interrupt request
// [R10] counter readable, writes ignored
// [R11] modulus is 15-bit period in pwm clocks
// [R12] software never writes zero modulus
// [R13] modulus buffered, applied at reload with load-okay
// [R14] deadtime readable, locked after write protect
// [R15] deadtime resets to all twelve ones
// [R16] deadtime bus cycles equal divisor times value minus one; at divisor one the code gives value
// [R17] generator b bits writable only with multiple timebase
// [R18] generator b enable opens pins two, three
// [R19] load-okay b transfers generator b buffers
// [R20] load-okay b read zero, write one
// [R21] software sets load-okay b before enable
// [R22] irq enable b gates flag b requests
// [R23] irq enable a gates flag a requests
// [R24] irq is flag and enable, held
`ifndef PWM_TIMEBASE_DEFS_SVH
`define PWM_TIMEBASE_DEFS_SVH

`define ADDR_ENC_A   8'h20
`define ADDR_FQC_A   8'h21
`define ADDR_CNT_A   8'h22
`define ADDR_MOD_A   8'h24
`define ADDR_DTM_A   8'h26
`define ADDR_ENC_B   8'h28
`define ADDR_CFG     8'h3e

`define FQC_INT_HI   7
`define FQC_INT_LO   4
`define FQC_HALF     3
`define FQC_DIV_HI   2
`define FQC_DIV_LO   1
`define FQC_FLAG     0

`define ENC_EN       7
`define ENC_LDOK     1
`define ENC_RIE      0

`define CFG_MTG      0
`define CFG_CENTER   1
`define CFG_WP       2
`define CFG_OCTL2    3
`define CFG_OCTL3    4

`define RST_DTM      12'hfff
`define RST_MOD      15'h0001

`endif

// File: verilog/pwm_timebase_pkg.sv
// types shared by the timebase block
// assumes the constants header is included by the design file
package pwm_timebase_pkg;

    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } cnt_dir_e;

    typedef struct packed {
        logic [15:0] rdata;
        logic [3:0]  int_buf;
        logic [3:0]  int_act;
        logic [3:0]  opp_cnt;
        logic        half_a;
        logic [1:0]  div_buf;
        logic [1:0]  div_act;
        logic [2:0]  pre_cnt;
        logic        flag_a;
        logic        arm_rf;
        logic        load_okay_a;
        logic        arm_lda;
        logic        rie_a;
        logic [14:0] cnt;
        logic [14:0] mod_buf;
        logic [14:0] mod_act;
        cnt_dir_e    dir;
        logic [11:0] dtm;
        logic [14:0] dt_bus;
        logic        multiple_timebase_select;
        logic        center;
        logic        wp;
        logic        octl2;
        logic        octl3;
        logic        enb;
        logic        load_okay_b;
        logic        arm_ldb;
        logic        rie_b;
        logic        irq_a;
        logic        irq_b;
        logic        gen_b_on;
        logic        pin2_en;
        logic        pin3_en;
        logic        load_b;
        logic        reload_a;
        logic        tick_a;
    } state_s;

endpackage

// File: verilog/pwm_timebase_reload_control.sv
// time base of generator a, its register file and the generator b
// enable register; assumes the bus master and generator b logic share
// CLK_SYS with this block
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "pwm_timebase_defs.svh"

module pwm_timebase_reload_control (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic        RELOAD_B,
    input  wire logic        RELOAD_FLAG_B,
    output logic      [15:0] RDATA,
    output logic             IRQ_A,
    output logic             IRQ_B,
    output logic             RELOAD_A,
    output logic             TICK_A,
    output logic      [14:0] DEADTIME_A,
    output logic             GEN_B_ENABLE,
    output logic             PIN_TWO_ENABLE,
    output logic             PIN_THREE_ENABLE,
    output logic             LOAD_B_STROBE
);
    import pwm_timebase_pkg::*;

    state_s s_r;
    state_s s_nxt;

    logic wr_enca;
    logic wr_fqca;
    logic wr_moda;
    logic wr_dtma;
    logic wr_encb;
    logic wr_cfg;
    logic rd_fqca;
    logic rd_enca;
    logic rd_encb;
    logic full_opp;
    logic half_opp;
    logic opp;
    logic reload_now;
    logic clr_flag;

    // divisor for a prescaler code
    function automatic logic [3:0] div_ratio(input logic [1:0] code);
        div_ratio = 4'h1 << code; // R04
    endfunction

    // deadtime in bus cycles, exact value when not divided
    function automatic logic [14:0] dt_cycles(input logic [1:0]  code,
                                              input logic [11:0] val);
        logic [14:0] prod;
        prod = {3'h0, val} << code;
        if (code == 2'h0 || val == 12'h000) begin
            dt_cycles = prod; // R16
        end else begin
            dt_cycles = prod - 15'h0001; // R16
        end
    endfunction

    assign wr_enca = WR && ADDR == `ADDR_ENC_A;
    assign wr_fqca = WR && ADDR == `ADDR_FQC_A;
    assign wr_moda = WR && ADDR == `ADDR_MOD_A;
    assign wr_dtma = WR && ADDR == `ADDR_DTM_A;
    assign wr_encb = WR && ADDR == `ADDR_ENC_B;
    assign wr_cfg  = WR && ADDR == `ADDR_CFG;
    assign rd_fqca = RD && ADDR == `ADDR_FQC_A;
    assign rd_enca = RD && ADDR == `ADDR_ENC_A;
    assign rd_encb = RD && ADDR == `ADDR_ENC_B;

    // counter reaches an end of period on a prescaled tick
    always_comb begin
        full_opp = 1'b0;
        half_opp = 1'b0;
        if (s_r.tick_a) begin
            if (!s_r.center) begin
                full_opp = s_r.cnt >= s_r.mod_act - 15'h0001;
            end else if (s_r.dir == DIR_UP) begin
                half_opp = s_r.cnt >= s_r.mod_act;
            end else begin
                full_opp = s_r.cnt == 15'h0000;
            end
        end
    end

    assign opp        = full_opp || (half_opp && s_r.half_a); // R03
    assign reload_now = opp && s_r.opp_cnt == s_r.int_act; // R01
    // a reload in the same cycle voids the pending clear
    assign clr_flag   = wr_fqca && WDATA[`FQC_FLAG] && s_r.arm_rf
                        && !reload_now; // R07 R08

    always_comb begin
        s_nxt        = s_r;
        s_nxt.rdata  = 16'h0000;
        s_nxt.load_b = 1'b0;

        // prescaler: tick marks one pwm clock period
        if ({1'b0, s_r.pre_cnt} >= div_ratio(s_r.div_act) - 4'h1) begin
            s_nxt.pre_cnt = 3'h0; // R04
            s_nxt.tick_a  = 1'b1;
        end else begin
            s_nxt.pre_cnt = s_r.pre_cnt + 3'h1;
            s_nxt.tick_a  = 1'b0;
        end

        // counter, edge or center aligned
        if (s_r.tick_a) begin
            case (s_r.dir)
                DIR_UP: begin
                    if (!s_r.center) begin
                        if (full_opp) begin
                            s_nxt.cnt = 15'h0000;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 15'h0001;
                        end
                    end else if (half_opp) begin
                        s_nxt.dir = DIR_DOWN;
                        s_nxt.cnt = s_r.cnt - 15'h0001;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 15'h0001;
                    end
                end
                DIR_DOWN: begin
                    if (!s_r.center || full_opp) begin
                        s_nxt.dir = DIR_UP;
                        s_nxt.cnt = s_r.center ? 15'h0001 : 15'h0000;
                    end else begin
                        s_nxt.cnt = s_r.cnt - 15'h0001;
                    end
                end
                default: begin
                    s_nxt.dir = DIR_UP;
                    s_nxt.cnt = 15'h0000;
                end
            endcase
        end

        // reload opportunities and reload cycles
        s_nxt.reload_a = reload_now;
        if (opp) begin
            if (reload_now) begin
                s_nxt.opp_cnt = 4'h0;
                s_nxt.int_act = s_r.int_buf; // R02
                s_nxt.arm_rf  = 1'b0; // R08
                if (s_r.load_okay_a) begin
                    s_nxt.div_act = s_r.div_buf; // R05
                    s_nxt.mod_act = s_r.mod_buf; // R13 R11
                    s_nxt.load_okay_a   = 1'b0;
                end
            end else begin
                s_nxt.opp_cnt = s_r.opp_cnt + 4'h1; // R01
            end
        end

        // frequency control a
        if (rd_fqca) begin
            s_nxt.arm_rf = s_r.flag_a; // R07
        end
        if (wr_fqca) begin
            s_nxt.int_buf = WDATA[`FQC_INT_HI:`FQC_INT_LO];
            s_nxt.half_a  = WDATA[`FQC_HALF];
            s_nxt.div_buf = WDATA[`FQC_DIV_HI:`FQC_DIV_LO];
            s_nxt.arm_rf  = 1'b0;
        end
        if (clr_flag) begin
            s_nxt.flag_a = 1'b0; // R07 R09
        end
        if (reload_now) begin
            s_nxt.flag_a = 1'b1; // R06
        end

        // enable control a: load-okay set only after reading it as zero
        if (rd_enca) begin
            s_nxt.arm_lda = !s_r.load_okay_a;
        end
        if (wr_enca) begin
            s_nxt.rie_a   = WDATA[`ENC_RIE];
            s_nxt.arm_lda = 1'b0;
            if (!WDATA[`ENC_LDOK]) begin
                s_nxt.load_okay_a = 1'b0;
            end else if (s_r.arm_lda) begin
                s_nxt.load_okay_a = 1'b1;
            end
        end

        // modulus, buffered; zero is left to software
        if (wr_moda) begin
            s_nxt.mod_buf = WDATA[14:0]; // R13
        end

        // deadtime, locked by write protect
        if (wr_dtma && !s_r.wp) begin
            s_nxt.dtm = WDATA[11:0]; // R14
        end
        s_nxt.dt_bus = dt_cycles(s_r.div_act, s_r.dtm); // R16

        // own configuration; write protect sticks until reset
        if (wr_cfg) begin
            s_nxt.multiple_timebase_select    = WDATA[`CFG_MTG];
            s_nxt.center = WDATA[`CFG_CENTER];
            s_nxt.wp     = s_r.wp || WDATA[`CFG_WP];
            s_nxt.octl2  = WDATA[`CFG_OCTL2];
            s_nxt.octl3  = WDATA[`CFG_OCTL3];
        end

        // enable control b, live only with multiple time bases
        if (rd_encb) begin
            s_nxt.arm_ldb = s_r.multiple_timebase_select && !s_r.load_okay_b; // R20
        end
        if (RELOAD_B && s_r.multiple_timebase_select && s_r.load_okay_b) begin
            s_nxt.load_okay_b  = 1'b0; // R19 R20
            s_nxt.load_b = 1'b1; // R19
        end
        if (wr_encb && s_r.multiple_timebase_select) begin
            s_nxt.enb     = WDATA[`ENC_EN]; // R17
            s_nxt.rie_b   = WDATA[`ENC_RIE]; // R17
            s_nxt.arm_ldb = 1'b0;
            if (!WDATA[`ENC_LDOK]) begin
                s_nxt.load_okay_b = 1'b0; // R20
            end else if (s_r.arm_ldb) begin
                s_nxt.load_okay_b = 1'b1; // R20
            end
        end

        // outputs, registered from the next state
        s_nxt.irq_a    = s_nxt.flag_a && s_nxt.rie_a; // R23 R24 R09
        s_nxt.irq_b    = RELOAD_FLAG_B && s_nxt.rie_b
                         && s_nxt.multiple_timebase_select; // R22 R24
        s_nxt.gen_b_on = s_nxt.enb && s_nxt.multiple_timebase_select; // R18
        s_nxt.pin2_en  = s_nxt.gen_b_on || s_nxt.octl2; // R18
        s_nxt.pin3_en  = s_nxt.gen_b_on || s_nxt.octl3; // R18

        // read data stand only in the cycle after the strobe
        if (RD) begin
            case (ADDR)
                `ADDR_ENC_A: begin
                    s_nxt.rdata = {14'h0000, s_r.load_okay_a, s_r.rie_a};
                end
                `ADDR_FQC_A: begin
                    s_nxt.rdata = {8'h00, s_r.int_buf, s_r.half_a,
                                   s_r.div_buf, s_r.flag_a}; // R02 R05
                end
                `ADDR_CNT_A: begin
                    s_nxt.rdata = {1'b0, s_r.cnt}; // R10
                end
                `ADDR_MOD_A: begin
                    s_nxt.rdata = {1'b0, s_r.mod_buf}; // R13
                end
                `ADDR_DTM_A: begin
                    s_nxt.rdata = {4'h0, s_r.dtm}; // R14
                end
                `ADDR_ENC_B: begin
                    s_nxt.rdata = {8'h00, s_r.enb && s_r.multiple_timebase_select, 5'h00,
                                   s_r.load_okay_b && s_r.multiple_timebase_select,
                                   s_r.rie_b && s_r.multiple_timebase_select}; // R17
                end
                `ADDR_CFG: begin
                    s_nxt.rdata = {11'h000, s_r.octl3, s_r.octl2,
                                   s_r.wp, s_r.center, s_r.multiple_timebase_select};
                end
                default: begin
                    s_nxt.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            s_r         <= '0;
            s_r.dir     <= DIR_UP;
            s_r.mod_buf <= `RST_MOD;
            s_r.mod_act <= `RST_MOD;
            s_r.dtm     <= `RST_DTM; // R15
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    assign RDATA            = s_r.rdata;
    assign IRQ_A            = s_r.irq_a;
    assign IRQ_B            = s_r.irq_b;
    assign RELOAD_A         = s_r.reload_a;
    assign TICK_A           = s_r.tick_a;
    assign DEADTIME_A       = s_r.dt_bus;
    assign GEN_B_ENABLE     = s_r.gen_b_on;
    assign PIN_TWO_ENABLE   = s_r.pin2_en;
    assign PIN_THREE_ENABLE = s_r.pin3_en;
    assign LOAD_B_STROBE    = s_r.load_b;

    // checks
    property p_reload_flag;
        @(posedge CLK_SYS) disable iff (RST)
        CE && reload_now |=> s_r.flag_a && RELOAD_A;
    endproperty
    a_reload_flag: assert property (p_reload_flag) // R06
        else $error("reload did not set flag");

    property p_mod_load;
        @(posedge CLK_SYS) disable iff (RST)
        CE && reload_now && s_r.load_okay_a
        |=> s_r.mod_act == $past(s_r.mod_buf) && !s_r.load_okay_a;
    endproperty
    a_mod_load: assert property (p_mod_load) // R13
        else $error("modulus not taken at reload");

    property p_mod_hold;
        @(posedge CLK_SYS) disable iff (RST)
        CE && !s_r.load_okay_a |=> $stable(s_r.mod_act);
    endproperty
    a_mod_hold: assert property (p_mod_hold) // R13
        else $error("modulus changed without load-okay");

    property p_clear_unarmed;
        @(posedge CLK_SYS) disable iff (RST)
        CE && s_r.flag_a && !s_r.arm_rf |=> s_r.flag_a;
    endproperty
    a_clear_unarmed: assert property (p_clear_unarmed) // R08
        else $error("flag cleared without read");

    property p_irq_a;
        @(posedge CLK_SYS) disable iff (RST)
        CE && reload_now && s_r.rie_a && !wr_enca |=> IRQ_A;
    endproperty
    a_irq_a: assert property (p_irq_a) // R24
        else $error("irq a differs from flag and enable");

    property p_dtm_lock;
        @(posedge CLK_SYS) disable iff (RST)
        CE && s_r.wp && wr_dtma |=> $stable(s_r.dtm);
    endproperty
    a_dtm_lock: assert property (p_dtm_lock) // R14
        else $error("deadtime written after protect");

    property p_encb_zero;
        @(posedge CLK_SYS) disable iff (RST)
        CE && rd_encb && !s_r.multiple_timebase_select |=> RDATA == 16'h0000;
    endproperty
    a_encb_zero: assert property (p_encb_zero) // R17
        else $error("enable b bits visible without mtg");

    property p_cnt_read;
        @(posedge CLK_SYS) disable iff (RST)
        CE && RD && ADDR == `ADDR_CNT_A
        |=> RDATA == {1'b0, $past(s_r.cnt)};
    endproperty
    a_cnt_read: assert property (p_cnt_read) // R10
        else $error("counter read mismatch");

    property p_load_b;
        @(posedge CLK_SYS) disable iff (RST)
        CE && RELOAD_B && s_r.multiple_timebase_select && s_r.load_okay_b && !wr_encb
        |=> LOAD_B_STROBE && !s_r.load_okay_b;
    endproperty
    a_load_b: assert property (p_load_b) // R19
        else $error("load b not transferred");

    // divider only moves at a reload that sees load-okay
    property p_div_hold;
        @(posedge CLK_SYS) disable iff (RST)
        CE && !s_r.load_okay_a |=> $stable(s_r.div_act);
    endproperty
    a_div_hold: assert property (p_div_hold) // R05
        else $error("divider changed without load-okay");

    property p_interval_load;
        @(posedge CLK_SYS) disable iff (RST)
        CE && reload_now |=> s_r.int_act == $past(s_r.int_buf);
    endproperty
    a_interval_load: assert property (p_interval_load) // R02
        else $error("interval not taken at reload");

    property p_encb_lock;
        @(posedge CLK_SYS) disable iff (RST)
        CE && wr_encb && !s_r.multiple_timebase_select
        |=> $stable({s_r.enb, s_r.load_okay_b, s_r.rie_b});
    endproperty
    a_encb_lock: assert property (p_encb_lock) // R17
        else $error("enable b bits written without mtg");

endmodule

// File: bench/pwm_timebase_reload_control_bench.sv
// self-checking bench for the generator a time base and generator b enables
// assumes the design registers and the constants header of verilog/
`timescale 1ns/1ps
`include "pwm_timebase_defs.svh"

module pwm_timebase_reload_control_bench;
    logic        CLK_SYS, RST, CE, WR, RD, RELOAD_B, RELOAD_FLAG_B;
    logic [7:0]  ADDR;
    logic [15:0] WDATA, RDATA;
    logic        IRQ_A, IRQ_B, RELOAD_A, TICK_A, GEN_B_ENABLE;
    logic        PIN_TWO_ENABLE, PIN_THREE_ENABLE, LOAD_B_STROBE;
    logic [14:0] DEADTIME_A;
    int          miscompares = 0;
    int          check_count = 0;

    pwm_timebase_reload_control u_dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RELOAD_B(RELOAD_B),
        .RELOAD_FLAG_B(RELOAD_FLAG_B), .RDATA(RDATA), .IRQ_A(IRQ_A),
        .IRQ_B(IRQ_B), .RELOAD_A(RELOAD_A), .TICK_A(TICK_A),
        .DEADTIME_A(DEADTIME_A), .GEN_B_ENABLE(GEN_B_ENABLE),
        .PIN_TWO_ENABLE(PIN_TWO_ENABLE),
        .PIN_THREE_ENABLE(PIN_THREE_ENABLE), .LOAD_B_STROBE(LOAD_B_STROBE));

    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    task automatic final_report;
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK_SYS);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK_SYS);
        WR    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK_SYS);
        RD   <= 1'b0;
        #1 d = RDATA;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(nm, e, d);
    endtask

    task automatic wait_rl;
        int n;
        n = 0;
        @(posedge CLK_SYS);
        #1;
        while (RELOAD_A !== 1'b1 && n < 3000) begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
        if (n >= 3000) begin
            $display("[FAIL] reload wait expected pulse seen none");
            miscompares++;
            final_report();
        end
    endtask

    // distance in clocks between two reload pulses
    task automatic period(input string nm, input int e);
        int n;
        wait_rl();
        n = 0;
        do begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end while (RELOAD_A !== 1'b1 && n < 3000);
        chk(nm, 16'(e), 16'(n));
    endtask

    task automatic set_ldok_a;
        logic [15:0] d;
        rd(`ADDR_ENC_A, d);
        wr(`ADDR_ENC_A, 16'h0002);
    endtask

    task automatic t_reset;
        rchk("deadtime reg", `ADDR_DTM_A, 16'h0fff);
        chk("deadtime out", 16'h0fff, {1'b0, DEADTIME_A});
        rchk("modulus", `ADDR_MOD_A, 16'h0001);
        rchk("freq ctrl", `ADDR_FQC_A, 16'h0001);
        rchk("gen b ctrl", `ADDR_ENC_B, 16'h0000);
        wr(`ADDR_CNT_A, 16'h1234);
        rchk("counter", `ADDR_CNT_A, 16'h0000);
        rchk("unmapped", 8'h30, 16'h0000);
    endtask

    task automatic t_modulus;
        wr(`ADDR_MOD_A, 16'h0005);
        rchk("modulus buf", `ADDR_MOD_A, 16'h0005);
        wait_rl();
        period("mod unloaded", 1);
        set_ldok_a();
        wait_rl();
        period("mod loaded", 5);
    endtask

    task automatic t_interval;
        logic [3:0] k [3] = '{4'h3, 4'hf, 4'h0};
        foreach (k[i]) begin
            wr(`ADDR_FQC_A, {8'h00, k[i], 4'h0});
            rchk("interval buf", `ADDR_FQC_A, {8'h00, k[i], 4'h1});
            wait_rl();
            period("interval", (k[i] + 1) * 5);
        end
    endtask

    task automatic t_divider;
        int p;
        int dt;
        int n;
        wr(`ADDR_DTM_A, 16'h0005);
        for (int c = 3; c >= 0; c--) begin
            p = 1 << c;
            wr(`ADDR_FQC_A, 16'(c * 2));
            rchk("divider buf", `ADDR_FQC_A, 16'(c * 2 + 1));
            if (c == 3)
                period("divider unloaded", 5);
            set_ldok_a();
            wait_rl();
            period("divider", 5 * p);
            dt = (p == 1) ? 5 : p * 5 - 1;
            chk("deadtime", 16'(dt), {1'b0, DEADTIME_A});
            // every divisor divides the window, so phase does not matter
            n = 0;
            repeat (40) begin
                @(posedge CLK_SYS);
                #1 n += int'(TICK_A === 1'b1);
            end
            chk("tick rate", 16'(40 / p), 16'(n));
        end
    endtask

    task automatic t_half;
        logic [15:0] cfg [3] = '{16'h0000, 16'h0002, 16'h0002};
        logic [15:0] fqc [3] = '{16'h0008, 16'h0000, 16'h0008};
        int          exp [3] = '{5, 10, 5};
        foreach (exp[i]) begin
            wr(`ADDR_CFG, cfg[i]);
            wr(`ADDR_FQC_A, fqc[i]);
            wait_rl();
            period("half cycle", exp[i]);
        end
        wr(`ADDR_CFG, 16'h0000);
    endtask

    task automatic t_flag;
        wr(`ADDR_FQC_A, 16'h00f0);
        wait_rl();
        wait_rl();
        wr(`ADDR_ENC_A, 16'h0001);
        repeat (2) @(posedge CLK_SYS);
        chk("irq a on", 16'h0001, {15'h0, IRQ_A});
        wr(`ADDR_FQC_A, 16'h00f1);
        rchk("flag unarmed", `ADDR_FQC_A, 16'h00f1);
        wait_rl();
        wr(`ADDR_FQC_A, 16'h00f1);
        rchk("flag reload", `ADDR_FQC_A, 16'h00f1);
        wait_rl();
        rchk("flag read", `ADDR_FQC_A, 16'h00f1);
        wr(`ADDR_FQC_A, 16'h00f1);
        repeat (2) @(posedge CLK_SYS);
        chk("irq a off", 16'h0000, {15'h0, IRQ_A});
        rchk("flag clear", `ADDR_FQC_A, 16'h00f0);
        wr(`ADDR_ENC_A, 16'h0000);
        wait_rl();
        repeat (2) @(posedge CLK_SYS);
        chk("irq a masked", 16'h0000, {15'h0, IRQ_A});
        wr(`ADDR_FQC_A, 16'h0000);
    endtask

    task automatic t_gen_b;
        logic [15:0] d;
        logic        seen;
        wr(`ADDR_ENC_B, 16'h0083);
        rchk("enc b masked", `ADDR_ENC_B, 16'h0000);
        wr(`ADDR_CFG, 16'h0001);
        rchk("enc b ignored", `ADDR_ENC_B, 16'h0000);
        wr(`ADDR_ENC_B, 16'h0002);
        rchk("ldok b", `ADDR_ENC_B, 16'h0002);
        @(posedge CLK_SYS);
        RELOAD_B <= 1'b1;
        @(posedge CLK_SYS);
        RELOAD_B <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            #1 seen = seen | (LOAD_B_STROBE === 1'b1);
            @(posedge CLK_SYS);
        end
        chk("load b strobe", 16'h0001, {15'h0, seen});
        rchk("ldok b cleared", `ADDR_ENC_B, 16'h0000);
        wr(`ADDR_ENC_B, 16'h0002);
        wr(`ADDR_ENC_B, 16'h0083);
        rchk("ldok b kept", `ADDR_ENC_B, 16'h0083);
        RELOAD_FLAG_B <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        chk("gen b en", 16'h0001, {15'h0, GEN_B_ENABLE});
        chk("pins", 16'h0003,
            {14'h0, PIN_THREE_ENABLE, PIN_TWO_ENABLE});
        chk("irq b on", 16'h0001, {15'h0, IRQ_B});
        wr(`ADDR_ENC_B, 16'h0000);
        wr(`ADDR_CFG, 16'h0009);
        repeat (3) @(posedge CLK_SYS);
        chk("irq b off", 16'h0000, {15'h0, IRQ_B});
        chk("pins ctl", 16'h0001,
            {14'h0, PIN_THREE_ENABLE, PIN_TWO_ENABLE});
        RELOAD_FLAG_B <= 1'b0;
    endtask

    task automatic t_protect;
        wr(`ADDR_DTM_A, 16'h0123);
        rchk("deadtime rw", `ADDR_DTM_A, 16'h0123);
        // clock enable low must swallow the write
        @(posedge CLK_SYS);
        CE <= 1'b0;
        wr(`ADDR_DTM_A, 16'h0789);
        CE <= 1'b1;
        rchk("deadtime frozen", `ADDR_DTM_A, 16'h0123);
        wr(`ADDR_CFG, 16'h0004);
        wr(`ADDR_DTM_A, 16'h0456);
        rchk("deadtime locked", `ADDR_DTM_A, 16'h0123);
    endtask

    initial begin
        RST = 1'b1;
        CE = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 16'h0000;
        RELOAD_B = 1'b0;
        RELOAD_FLAG_B = 1'b0;
        repeat (6) @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        t_reset();
        t_modulus();
        t_interval();
        t_divider();
        t_half();
        t_flag();
        t_gen_b();
        t_protect();
        final_report();
    end
endmodule
